// ### shared/cbrc_map.vh
`ifndef CBRC_MAP_VH
`define CBRC_MAP_VH
// Register byte offsets on the APB bus.
`define CBRC_CTRL_OFS 12'h000
`define CBRC_STAT_OFS 12'h004
`define CBRC_IRQ_STAT_OFS 12'h008
`define CBRC_IRQ_EN_OFS 12'h00C
`define CBRC_IRQ_CLR_OFS 12'h010
`define CBRC_CTRL_RST 32'h0000_0000
`define CBRC_IRQ_EN_RST 4'h0
// Control bit positions.
`define CBRC_CTRL_IOM_KEEP 0
`define CBRC_CTRL_FRC_KEEP 1
// Interrupt status bit positions.
`define CBRC_EV_DONE 0
`define CBRC_EV_FAIL 1
`define CBRC_EV_MISMATCH 2
`define CBRC_EV_SKIP 3
// Timing: clock in kHz, hold time in ms, debounce in ms.
`define CBRC_CLK_KHZ 10000
`define CBRC_HOLD_MS 3000
`define CBRC_HOLD_CYC (`CBRC_HOLD_MS * `CBRC_CLK_KHZ)
`define CBRC_DEB_MS 20
`define CBRC_DEB_CYC (`CBRC_DEB_MS * `CBRC_CLK_KHZ)
// Operation codes to the transfer engine.
`define CBRC_OP_NONE 2'h0
`define CBRC_OP_BACKUP 2'h1
`define CBRC_OP_RESTORE 2'h2
`define CBRC_OP_COMPARE 2'h3
`endif

// ### logic/cbrc_top.v
// Operation
// - Switch 7 on at power-up restores
// - Restore moves all areas as one
// - Restore overrides startup auto-transfer
// - Write-protect on skips the restore
// - Restore clears I/O and forced states
// - Retain flag plus setting keeps I/O
// - Retain flag plus setting keeps forces
// - After backup, lock in halted state
// - Three-second hold, switch off compares
// - Compare checks every area together
// - Compare allowed in any operating state
// - Three-second hold, switch on backs up
// - Sequences never time out
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "cbrc_map.vh"
module cbrc_top #(
	parameter HOLD_CYC = `CBRC_HOLD_CYC,
	parameter DEB_CYC = `CBRC_DEB_CYC
) (
	// Clock and power-on reset.
	input wire pclk,
	input wire presetn,
	// APB register port.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Front-panel switches and the card power button, all levels.
	input wire sw_backup_select,
	input wire sw_auto_transfer,
	input wire sw_write_protect,
	input wire card_button,
	// Hold flags as stored with the snapshot on the card.
	input wire io_memory_retain_flag,
	input wire forced_state_retain_flag,
	// Transfer engine that moves the snapshot to or from the card.
	output reg xfer_start,
	output reg [1:0] xfer_op,
	input wire xfer_done,
	input wire xfer_ok,
	input wire xfer_match,
	// Startup and post-restore pulses to the rest of the unit.
	output reg auto_transfer_go,
	output reg normal_start,
	output reg clear_io_memory,
	output reg clear_forced_states,
	// Status levels.
	output reg mode_lock,
	output reg busy,
	output reg irq
);
	// Sequencer states.
	// Boot looks at the switches once, right after the power cycle.
	localparam S_BOOT = 3'd0;
	// Idle waits for a long press.
	localparam S_IDLE = 3'd1;
	// Wait holds while the engine works, for as long as it takes.
	localparam S_WAIT = 3'd2;
	// Post sends the clear pulses and decides on the lock.
	localparam S_POST = 3'd3;
	// Lock is left only through reset.
	localparam S_LOCK = 3'd4;

	// Sequencer.
	reg [2:0] state;
	reg [2:0] next_state;
	reg [1:0] op;

	// Register bits.
	reg iom_keep;
	reg frc_keep;
	reg [3:0] irq_stat;
	reg [3:0] irq_en;
	reg [3:0] next_irq_stat;

	// Button path.
	reg btn_stable;
	reg [31:0] deb_cnt;
	reg [31:0] hold_cnt;
	reg hold_fired;
	reg hold_pulse;

	// Event pulses into the status.
	reg [3:0] ev;
	wire apb_wr;
	wire apb_rd;
	wire [3:0] clr_mask;
	wire boot_restore;
	wire [1:0] hold_op;

	// Matches a byte offset against the mapped registers.
	function mapped;
		input [11:0] a;
		begin
			mapped = (a == `CBRC_CTRL_OFS) || (a == `CBRC_STAT_OFS) || (a == `CBRC_IRQ_STAT_OFS) ||
				(a == `CBRC_IRQ_EN_OFS) || (a == `CBRC_IRQ_CLR_OFS);
		end
	endfunction

	// Power-up restore wanted; protect on means the power-up restore reads nothing from the card.
	function restore_wanted;
		input sel;
		input wp;
		begin
			restore_wanted = sel & ~wp;
		end
	endfunction

	// Operation started by a long press: select on backs up, select off compares.
	function [1:0] hold_operation;
		input sel;
		begin
			if (sel) begin
				hold_operation = `CBRC_OP_BACKUP;
			end else begin
				hold_operation = `CBRC_OP_COMPARE;
			end
		end
	endfunction

	// Interval end test shared by the debounce and the hold counters.
	function count_done;
		input [31:0] cnt;
		input [31:0] limit;
		begin
			count_done = (cnt >= limit - 32'h0000_0001);
		end
	endfunction

	// Write strobe: the slave only acts on the access edge at which it shows ready.
	assign apb_wr = psel & penable & pwrite & pready;
	// Read data is fetched on the setup edge, so it already stands when ready rises.
	assign apb_rd = psel & ~penable & ~pwrite;
	// Write-one-to-clear mask; writes to other offsets leave the status alone.
	assign clr_mask = (apb_wr && paddr == `CBRC_IRQ_CLR_OFS) ? pwdata[3:0] : 4'h0;
	// Both the next-state logic and the sequencer read the same boot decision.
	assign boot_restore = restore_wanted(sw_backup_select, sw_write_protect);
	// The select switch is read when the hold completes, not when the press began.
	assign hold_op = hold_operation(sw_backup_select);

	// Ready answers in the first access cycle and drops after, so no access has a wait state.
	// The error flag stands with ready, for any offset outside the map.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped(paddr);
		end
	end

	// Read mux, latched on the setup edge; the clear register and unmapped offsets read zero.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (apb_rd) begin
			case (paddr)
				`CBRC_CTRL_OFS: prdata <= {30'h0000_0000, frc_keep, iom_keep};
				`CBRC_STAT_OFS: prdata <= {24'h00_0000, btn_stable, mode_lock, busy, state, op};
				`CBRC_IRQ_STAT_OFS: prdata <= {28'h000_0000, irq_stat};
				`CBRC_IRQ_EN_OFS: prdata <= {28'h000_0000, irq_en};
				default: prdata <= 32'h0000_0000;
			endcase
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

	// Startup keep settings; they only matter at the moment a restore finishes.
	// Reset clears them, so software must set them again while the restore runs.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iom_keep <= 1'b0;
			frc_keep <= 1'b0;
		end else if (apb_wr && paddr == `CBRC_CTRL_OFS) begin
			iom_keep <= pwdata[`CBRC_CTRL_IOM_KEEP];
			frc_keep <= pwdata[`CBRC_CTRL_FRC_KEEP];
		end
	end

	// Interrupt enable mask; the status bits stay sticky whether enabled or not.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en <= `CBRC_IRQ_EN_RST;
		end else if (apb_wr && paddr == `CBRC_IRQ_EN_OFS) begin
			irq_en <= pwdata[3:0];
		end
	end

	// Debounce: the button level is accepted only after it stays put for the whole window.
	// The counter restarts whenever the raw level returns, so contact chatter never passes.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			btn_stable <= 1'b0;
			deb_cnt <= 32'h0000_0000;
		end else if (card_button == btn_stable) begin
			deb_cnt <= 32'h0000_0000;
		end else if (count_done(deb_cnt, DEB_CYC)) begin
			btn_stable <= card_button;
			deb_cnt <= 32'h0000_0000;
		end else begin
			deb_cnt <= deb_cnt + 32'h0000_0001;
		end
	end

	// Hold timer fires once per press; an early release restarts it, so short taps never trigger.
	// Once fired, the press must end before another hold can be counted.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt <= 32'h0000_0000;
			hold_fired <= 1'b0;
			hold_pulse <= 1'b0;
		end else begin
			hold_pulse <= 1'b0;
			if (!btn_stable) begin
				hold_cnt <= 32'h0000_0000;
				hold_fired <= 1'b0;
			end else if (!hold_fired) begin
				if (count_done(hold_cnt, HOLD_CYC)) begin
					hold_pulse <= 1'b1;
					hold_fired <= 1'b1;
				end else begin
					hold_cnt <= hold_cnt + 32'h0000_0001;
				end
			end
		end
	end

	// Next state; the wait state has no timer because a transfer may run for minutes.
	always @* begin
		next_state = state;
		case (state)
			// Boot always leaves after one cycle; the switches are read only once.
			S_BOOT: next_state = boot_restore ? S_WAIT : S_IDLE;
			S_IDLE: next_state = hold_pulse ? S_WAIT : S_IDLE;
			S_WAIT: next_state = xfer_done ? S_POST : S_WAIT;
			S_POST: next_state = (op == `CBRC_OP_COMPARE) ? S_IDLE : S_LOCK;
			S_LOCK: next_state = S_LOCK;
			default: next_state = S_IDLE;
		endcase
	end

	// Sequencer and its outputs; reset stands for the power cycle, the only way out of the lock.
	// Outputs are registered here so every pin comes straight from a flip-flop.
	// Pulses default low each cycle and rise for exactly one cycle when a step fires.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_BOOT;
			op <= `CBRC_OP_NONE;
			xfer_start <= 1'b0;
			xfer_op <= `CBRC_OP_NONE;
			auto_transfer_go <= 1'b0;
			normal_start <= 1'b0;
			clear_io_memory <= 1'b0;
			clear_forced_states <= 1'b0;
			mode_lock <= 1'b0;
			busy <= 1'b0;
			ev <= 4'h0;
		end else begin
			state <= next_state;
			xfer_start <= 1'b0;
			auto_transfer_go <= 1'b0;
			normal_start <= 1'b0;
			clear_io_memory <= 1'b0;
			clear_forced_states <= 1'b0;
			ev <= 4'h0;
			case (state)
				S_BOOT: begin
					// Restore wins over the startup auto-transfer; protect on blocks the card read.
					if (boot_restore) begin
						op <= `CBRC_OP_RESTORE;
						xfer_op <= `CBRC_OP_RESTORE;
						xfer_start <= 1'b1;
						busy <= 1'b1;
					end else begin
						// Protect on with select on leaves the unit idle and records the skip.
						ev[`CBRC_EV_SKIP] <= sw_backup_select & sw_write_protect;
						auto_transfer_go <= sw_auto_transfer & ~sw_backup_select;
						normal_start <= ~sw_backup_select;
					end
				end
				S_IDLE: begin
					if (hold_pulse) begin
						// Any operating state is fine here: the lock only follows backup or restore.
						op <= hold_op;
						xfer_op <= hold_op;
						xfer_start <= 1'b1;
						busy <= 1'b1;
					end
				end
				S_WAIT: begin
					// Results are sampled only with done; between pulses they mean nothing.
					if (xfer_done) begin
						busy <= 1'b0;
						ev[`CBRC_EV_DONE] <= xfer_ok;
						ev[`CBRC_EV_FAIL] <= ~xfer_ok;
						ev[`CBRC_EV_MISMATCH] <= (op == `CBRC_OP_COMPARE) & xfer_ok & ~xfer_match;
					end
				end
				S_POST: begin
					// Clears follow a restore unless a flag and its keep setting both ask to hold.
					// Backup and restore both end in the lock; compare leaves the modes free.
					if (op == `CBRC_OP_RESTORE) begin
						clear_io_memory <= ~(io_memory_retain_flag & iom_keep);
						clear_forced_states <= ~(forced_state_retain_flag & frc_keep);
					end
					if (op != `CBRC_OP_COMPARE) begin
						mode_lock <= 1'b1;
					end
				end
				// Only a power cycle, seen here as reset, leaves the lock.
				S_LOCK: mode_lock <= 1'b1;
				default: busy <= 1'b0;
			endcase
		end
	end

	// Next status: a new event wins over a clear in the same cycle, so no event is lost.
	always @* begin
		next_irq_stat = (irq_stat & ~clr_mask) | ev;
	end

	// Sticky status and a registered level interrupt, high while any enabled bit is set.
	// The level is taken from the next status so it moves in step with the bits.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= 4'h0;
			irq <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq <= |(next_irq_stat & irq_en);
		end
	end
endmodule // cbrc_top

// ### verif/cbrc_monitor.sv
`timescale 1ns/10ps
module cbrc_monitor (
	input pclk,
	input presetn,
	input psel,
	input penable,
	input [11:0] paddr,
	input pready,
	input pslverr,
	input sw_backup_select,
	input sw_write_protect,
	input card_button,
	input xfer_start,
	input [1:0] xfer_op,
	input xfer_done,
	input normal_start,
	input auto_transfer_go,
	input mode_lock,
	input busy
);
	// One clock domain, so every check shares it and sleeps in reset.
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_next: assert property (psel && !penable |=> pready) else $error("late ready");
	a_unmapped_err: assert property (psel && penable && pready && paddr > 12'h010 |-> pslverr) else $error("no error");
	a_restore_cond: assert property (xfer_start && xfer_op == 2'h2 |-> $past(sw_backup_select) && !$past(sw_write_protect))
		else $error("bad restore");
	a_boot_priority: assert property (normal_start || auto_transfer_go |-> !$past(sw_backup_select))
		else $error("bad boot");
	a_hold_time: assert property (xfer_start && xfer_op != 2'h2 |-> $past(card_button, 20))
		else $error("short hold");
	a_op_select: assert property (xfer_start && xfer_op != 2'h2 |-> xfer_op == ($past(sw_backup_select) ? 2'h1 : 2'h3))
		else $error("bad op");
	a_busy_held: assert property (xfer_start ##1 !xfer_done [*8] |-> busy) else $error("gave up");
	a_lock_stays: assert property (mode_lock |=> mode_lock) else $error("lock lost");
	c_restore: cover property (xfer_start && xfer_op == 2'h2);
	c_compare: cover property (xfer_start && xfer_op == 2'h3);
	c_lock: cover property ($rose(mode_lock));
endmodule // cbrc_monitor
bind cbrc_top cbrc_monitor mon_u (.*);

// ### verif/cbrc_card_model.sv
`timescale 1ns/10ps
module cbrc_card_model (
	input pclk,
	input xfer_start,
	input [7:0] dly,
	input ok,
	input match,
	output reg xfer_done = 0,
	output reg xfer_ok = 0,
	output reg xfer_match = 0
);
	integer n = -1;
	// Answers after a chosen delay; result lines toggle outside the pulse so stale values never pass.
	always @(posedge pclk) begin
		n <= xfer_start ? dly : (n >= 0 ? n - 1 : -1);
		xfer_done <= n == 0;
		xfer_ok <= n == 0 ? ok : ~xfer_ok;
		xfer_match <= n == 0 ? match : ~xfer_match;
	end
endmodule // cbrc_card_model

// ### verif/card_backup_restore_compare_test.sv
`timescale 1ns/10ps
module card_backup_restore_compare_test;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, card_button = 0, ok = 1, match = 1;
	reg sw_backup_select = 0, sw_auto_transfer = 0, sw_write_protect = 0;
	reg io_memory_retain_flag = 0, forced_state_retain_flag = 0, e;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, q, r = 32'h09f4_719e;
	reg [7:0] dly = 8'h10;
	reg [1:0] op;
	wire [31:0] prdata;
	wire [1:0] xfer_op;
	wire pready, pslverr, xfer_start, xfer_done, xfer_ok, xfer_match, auto_transfer_go, normal_start;
	wire clear_io_memory, clear_forced_states, mode_lock, busy, irq;
	wire [5:0] ev = {clear_forced_states, xfer_done, xfer_start, clear_io_memory, auto_transfer_go, normal_start};
	integer bad_count = 0, samples_checked = 0, cnt[0:5];
	cbrc_top #(.HOLD_CYC(20), .DEB_CYC(3)) dut_u (.*);
	cbrc_card_model card_u (.*);
	// Clock at 10 MHz.
	always #50 pclk = ~pclk;
	// Pulses are counted so one-cycle outputs are never missed.
	always @(posedge pclk) begin
		for (int k = 0; k < 6; k++) cnt[k] <= cnt[k] + ev[k];
		if (xfer_start) op <= xfer_op;
	end
	function [31:0] lfsr(input [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task chk(input string s, input [31:0] x, input [31:0] g);
		begin
			samples_checked++;
			if (g !== x) begin
				bad_count++;
				$display("BAD %s exp %h got %h", s, x, g);
			end
		end
	endtask
	// The answer is taken at the rising edge where ready is seen high; only then is the request released.
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			q = prdata;
			e = pslverr;
			psel <= 0;
			penable <= 0;
			@(posedge pclk);
		end
	endtask
	task rd(input [11:0] a, input [31:0] x);
		begin
			apb(0, a, 0);
			chk("prdata", x, q);
		end
	endtask
	task boot(input b, input w);
		begin
			presetn <= 0;
			sw_backup_select <= b;
			sw_write_protect <= w;
			sw_auto_transfer <= 1;
			@(negedge pclk);
			cnt = '{default: 0};
			repeat (20) @(posedge pclk);
			presetn <= 1;
			repeat (5) @(posedge pclk);
		end
	endtask
	// The gap after release outlasts the debounce so the next press starts afresh.
	task press(input integer n);
		begin
			r = lfsr(r);
			dly <= r[7:0] | 8'h10;
			card_button <= 1;
			repeat (n) @(posedge pclk);
			card_button <= 0;
			repeat (6) @(posedge pclk);
		end
	endtask
	task summarize;
		begin
			if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
			else $display("[ FAIL ]");
			$finish;
		end
	endtask
	// A hang is cut short well past the expected run length.
	initial begin
		#1000000;
		bad_count++;
		summarize;
	end
	initial begin
		boot(0, 0);
		chk("normal", 1, cnt[0]);
		chk("autogo", 1, cnt[1]);
		apb(1, 12'h000, {30'h0, r[1:0]});
		rd(12'h000, {30'h0, r[1:0]});
		rd(12'h020, 0);
		chk("slverr", 1, e);
		apb(1, 12'h00c, 32'h0000_000f);
		press(15);
		press(15);
		chk("early", 0, cnt[3]);
		match <= 0;
		press(30);
		wait (cnt[4] == 1);
		repeat (6) @(posedge pclk);
		chk("cmp_op", 3, op);
		chk("irq", 1, irq);
		rd(12'h008, 32'h0000_0005);
		chk("free", 0, mode_lock);
		chk("busy", 0, busy);
		apb(1, 12'h010, 32'h0000_000f);
		apb(1, 12'h00c, 0);
		rd(12'h008, 0);
		sw_backup_select <= 1;
		match <= 1;
		press(30);
		wait (cnt[4] == 2);
		repeat (6) @(posedge pclk);
		chk("bak_op", 1, op);
		chk("lock", 1, mode_lock);
		chk("masked", 0, irq);
		rd(12'h008, 1);
		boot(1, 1);
		chk("skip", 0, cnt[3] + cnt[0]);
		rd(12'h008, 8);
		boot(1, 0);
		wait (cnt[4] == 1);
		repeat (6) @(posedge pclk);
		chk("rst_op", 2, op);
		chk("noauto", 0, cnt[1]);
		chk("clear", 1, cnt[2]);
		chk("clear_frc", 1, cnt[5]);
		chk("lock_rst", 1, mode_lock);
		io_memory_retain_flag <= 1;
		forced_state_retain_flag <= 1;
		boot(1, 0);
		apb(1, 12'h000, 32'h0000_0003);
		wait (cnt[4] == 1);
		repeat (6) @(posedge pclk);
		chk("keep_io", 0, cnt[2]);
		chk("keep_frc", 0, cnt[5]);
		summarize;
	end
endmodule // card_backup_restore_compare_test
